// [rtl/ebp_pkg.sv]
// Package: constants, modes, states and carriers of the external bus pin block
package ebp_pkg;

    // ****************************************
    // Register offsets (word index on the register port)
    // ****************************************
    localparam logic [3:0] OFF_SYS_CFG = 4'h0;
    localparam logic [3:0] OFF_MUX_DIR = 4'h1;
    localparam logic [3:0] OFF_MUX_OUT = 4'h2;
    localparam logic [3:0] OFF_ADR_DIR = 4'h3;
    localparam logic [3:0] OFF_ADR_OUT = 4'h4;
    localparam logic [3:0] OFF_SEL_DIR = 4'h5;
    localparam logic [3:0] OFF_SEL_CTRL = 4'h6;
    localparam logic [3:0] OFF_CS_WIN_FIRST = 4'h7;
    localparam logic [3:0] OFF_CS_WIN_LAST = 4'hA;
    localparam logic [3:0] OFF_STATUS = 4'hB;
    localparam logic [3:0] OFF_MUX_IN = 4'hC;
    localparam logic [3:0] OFF_ADR_IN = 4'hD;
    localparam logic [3:0] OFF_SEL_IN = 4'hE;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SYS_MODE_LSB = 0;
    localparam int SYS_SEG_LSB = 2;
    localparam int SYS_STYLE_BIT = 4;
    localparam int SYS_BUS8_BIT = 5;
    localparam int SEL_OUT_LSB = 0;
    localparam int SEL_OD_LSB = 4;
    localparam int SEL_ALT_LSB = 8;
    localparam int CSW_EN_BIT = 15;
    localparam int CSW_MASK_LSB = 8;
    localparam int CSW_BASE_LSB = 0;
    localparam int CSW_ADDR_LSB = 15;

    // ****************************************
    // Modes and reset values
    // ****************************************
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_DEMUX = 2'h1;
    localparam logic [1:0] MODE_MUX = 2'h2;
    localparam logic [15:0] SYS_CFG_RST = 16'h0000;
    localparam logic [15:0] DIR_RST = 16'h0000;
    localparam logic [15:0] OUT_RST = 16'h0000;
    localparam logic [15:0] CSW_RST = 16'h0000;
    localparam int CS_COUNT = 4;
    localparam int CS_SMALL_COUNT = 2;

    // ****************************************
    // Cycle counts of the access phases
    // ****************************************
    localparam logic [2:0] ALE_CYCLES = 3'h1;
    localparam logic [2:0] GAP_CYCLES = 3'h1;
    localparam logic [2:0] STROBE_CYCLES = 3'h4;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ALE = 5'b00010,
        ST_GAP = 5'b00100,
        ST_STROBE = 5'b01000,
        ST_FINISH = 5'b10000
    } ebp_state_t;

    typedef struct packed {
        logic write;
        logic fetch;
        logic [21:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } ebp_req_t;

endpackage

// [rtl/ebp_sync.sv]
// Three-stage pin synchroniser with a filter that follows stages two and three when they agree
module ebp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } ebp_sync_st_t;

    ebp_sync_st_t st;
    ebp_sync_st_t next_st;

    // No reset: the chain must keep sampling while the block is held in reset
    always_comb begin
        next_st = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.lvl = (~(st.s2 ^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.lvl);
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign dout = st.lvl;

endmodule

// [rtl/ebp_csdec.sv]
// Chip select window decoder
module ebp_csdec #(
    parameter bit LARGE = 1'b1
) (
    input wire logic [21:0] addr,
    input wire logic [3:0][15:0] win,
    output logic [3:0] hit
);

    function automatic logic win_match(input logic [21:0] a, input logic [15:0] w);
        logic [6:0] diff;
        diff = (a[21:ebp_pkg::CSW_ADDR_LSB] ^ w[ebp_pkg::CSW_BASE_LSB +: 7]) & w[ebp_pkg::CSW_MASK_LSB +: 7];
        return w[ebp_pkg::CSW_EN_BIT] & (diff == 7'h00);
    endfunction

    // Lowest numbered matching window wins, so at most one select is active
    always_comb begin
        logic taken;
        taken = 1'b0;
        hit = 4'h0;
        for (int i = 0; i < ebp_pkg::CS_COUNT; i++) begin
            if (!taken && (LARGE || i < ebp_pkg::CS_SMALL_COUNT) && win_match(addr, win[i])) begin // RULE_15 RULE_19
                hit[i] = 1'b1;
                taken = 1'b1;
            end
        end
    end

endmodule

// [rtl/ebp_pins.sv]
// External bus pin interface: strobes, address latch, bus ports, selects and registers
//
// Summary of operation
// RULE_01: Read strobe goes low for every external fetch or data read.
// RULE_02: Single-strobe style: low store strobe pulses on every external data write.
// RULE_03: Low-byte style: shared strobe for low-byte writes, or all writes on 8-bit bus.
// RULE_04: Strobe style is chosen by a bit in the system configuration register.
// RULE_05: Multiplexed modes pulse an address latch output for capturing the address.
// RULE_06: Fetch select sampled at reset; low boots external, high boots internal.
// RULE_07: Boards without internal program memory tie fetch select to zero.
// RULE_08: Muxed port is two 8-bit halves, per-pin direction, inputs tristated.
// RULE_09: Muxed port carries address/data when multiplexed and data when demultiplexed.
// RULE_10: Demultiplexed: low half data 0-7; high half data 8-15 or general I/O.
// RULE_11: Multiplexed: low half address/data; high half address-only on 8-bit bus.
// RULE_12: Address port is two 8-bit halves, per-pin direction, inputs tristated.
// RULE_13: Address port drives address when demultiplexed and after switching to multiplexed.
// RULE_14: Select port has four pins, per-pin direction, push/pull or open-drain.
// RULE_15: Select pins may carry chip selects; two and three only on large variant.
// RULE_16: Modes: single chip, demultiplexed, multiplexed 16 or 8 bit, 16-22 address bits.
// RULE_17: Low-byte style drives a separate high-byte store strobe pin.
// RULE_18: Address bits 16 to 21 leave on a separate 6-bit segment port.
// RULE_19: Strobes and chip selects are active low, selects only inside their window.
// RULE_20: Address latch pulse ends before shared lines turn from address to data.
module ebp_pins #(
    parameter bit LARGE_DERIVATIVE = 1'b1
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [3:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire ebp_pkg::ebp_req_t REQ,
    output logic DONE,
    output logic [15:0] DONE_RDATA,
    output logic BOOT_EXTERNAL,
    input wire logic EXTERNAL_FETCH_SELECT_N,
    output logic READ_STROBE_N,
    output logic LOW_BYTE_STORE_STROBE_N,
    output logic HIGH_BYTE_STORE_STROBE_N,
    output logic ADDRESS_LATCH,
    input wire logic [15:0] MUXED_BUS_I,
    output logic [15:0] MUXED_BUS_O,
    output logic [15:0] MUXED_BUS_OE,
    input wire logic [15:0] ADDRESS_PORT_I,
    output logic [15:0] ADDRESS_PORT_O,
    output logic [15:0] ADDRESS_PORT_OE,
    input wire logic [3:0] SELECT_PORT_I,
    output logic [3:0] SELECT_PORT_O,
    output logic [3:0] SELECT_PORT_OE,
    output logic [5:0] SEGMENT_O,
    output logic [5:0] SEGMENT_OE
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        ebp_pkg::ebp_state_t fsm;
        logic [2:0] cnt;
        ebp_pkg::ebp_req_t req;
        logic [15:0] sys_cfg;
        logic [15:0] mux_dir;
        logic [15:0] mux_out;
        logic [15:0] adr_dir;
        logic [15:0] adr_out;
        logic [3:0] sel_dir;
        logic [3:0] sel_out;
        logic [3:0] sel_od;
        logic [3:0] sel_alt;
        logic [3:0][15:0] cs_win;
        logic was_demux;
        logic in_reset;
        logic boot_ext;
        logic [15:0] rdata;
        logic done;
        logic [15:0] done_rdata;
        logic read_n;
        logic low_store_n;
        logic high_store_n;
        logic ale;
        logic [3:0] cs_n;
        logic [15:0] mux_o;
        logic [15:0] mux_oe;
        logic [15:0] adr_o;
        logic [15:0] adr_oe;
        logic [3:0] sel_o;
        logic [3:0] sel_oe;
        logic [5:0] seg_o;
        logic [5:0] seg_oe;
    } ebp_pins_st_t;

    ebp_pins_st_t st;
    ebp_pins_st_t next_st;

    function automatic logic [1:0] win_index(input logic [3:0] a);
        logic [3:0] d;
        d = a - ebp_pkg::OFF_CS_WIN_FIRST;
        return d[1:0];
    endfunction

    function automatic logic [5:0] seg_mask(input logic [1:0] w);
        case (w)
            2'h1: return 6'h03;
            2'h2: return 6'h0F;
            2'h3: return 6'h3F;
            default: return 6'h00;
        endcase
    endfunction

    // ****************************************
    // Pin synchronisers and chip select decode
    // ****************************************
    logic [36:0] pin_lvl;
    logic fetch_lvl;
    logic [3:0] sel_lvl;
    logic [15:0] adr_lvl;
    logic [15:0] mux_lvl;
    logic [21:0] cs_addr;
    logic [3:0] cs_hit;

    ebp_sync #(
        .W(37)
    ) u_sync (
        .clk(REF_CLK),
        .din({EXTERNAL_FETCH_SELECT_N, SELECT_PORT_I, ADDRESS_PORT_I, MUXED_BUS_I}),
        .dout(pin_lvl)
    );

    assign fetch_lvl = pin_lvl[36];
    assign sel_lvl = pin_lvl[35:32];
    assign adr_lvl = pin_lvl[31:16];
    assign mux_lvl = pin_lvl[15:0];
    assign cs_addr = (st.fsm == ebp_pkg::ST_IDLE) ? REQ.addr : st.req.addr;

    ebp_csdec #(
        .LARGE(LARGE_DERIVATIVE)
    ) u_csdec (
        .addr(cs_addr),
        .win(st.cs_win),
        .hit(cs_hit)
    );

    // ****************************************
    // Mode decode
    // ****************************************
    logic [1:0] mode;
    logic demux_mode;
    logic mux_mode;
    logic ext_mode;
    logic bus8;
    logic low_style;
    logic mux_high_own;
    logic adr_own;
    logic busy;

    assign mode = st.sys_cfg[ebp_pkg::SYS_MODE_LSB +: 2];
    assign demux_mode = (mode == ebp_pkg::MODE_DEMUX); // RULE_16
    assign mux_mode = (mode == ebp_pkg::MODE_MUX); // RULE_16
    assign ext_mode = demux_mode | mux_mode;
    assign bus8 = st.sys_cfg[ebp_pkg::SYS_BUS8_BIT];
    assign low_style = st.sys_cfg[ebp_pkg::SYS_STYLE_BIT]; // RULE_04
    assign mux_high_own = ext_mode & ~(demux_mode & bus8); // RULE_10
    assign adr_own = demux_mode | (mux_mode & st.was_demux); // RULE_13
    assign busy = (st.fsm != ebp_pkg::ST_IDLE);
    assign REQ_READY = ~busy & ext_mode & ~st.in_reset;

    // ****************************************
    // Register read mux
    // ****************************************
    logic [15:0] rd_val;

    always_comb begin
        rd_val = 16'h0000;
        case (REG_ADDR)
            ebp_pkg::OFF_SYS_CFG: rd_val = st.sys_cfg;
            ebp_pkg::OFF_MUX_DIR: rd_val = st.mux_dir;
            ebp_pkg::OFF_MUX_OUT: rd_val = st.mux_out;
            ebp_pkg::OFF_ADR_DIR: rd_val = st.adr_dir;
            ebp_pkg::OFF_ADR_OUT: rd_val = st.adr_out;
            ebp_pkg::OFF_SEL_DIR: rd_val = {12'h000, st.sel_dir};
            ebp_pkg::OFF_SEL_CTRL: rd_val = {4'h0, st.sel_alt, st.sel_od, st.sel_out};
            ebp_pkg::OFF_STATUS: rd_val = {13'h0000, st.was_demux, busy, st.boot_ext};
            ebp_pkg::OFF_MUX_IN: rd_val = mux_lvl;
            ebp_pkg::OFF_ADR_IN: rd_val = adr_lvl;
            ebp_pkg::OFF_SEL_IN: rd_val = {12'h000, sel_lvl};
            default: begin
                if (REG_ADDR >= ebp_pkg::OFF_CS_WIN_FIRST && REG_ADDR <= ebp_pkg::OFF_CS_WIN_LAST) begin
                    rd_val = st.cs_win[win_index(REG_ADDR)];
                end
            end
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic active;
        logic adr_phase;
        logic strobe;
        logic rd_access;
        logic wr_access;
        logic [15:0] bus_o;
        logic [15:0] bus_oe;
        logic [15:0] own;
        logic alt;
        logic drv;
        logic en;
        active = 1'b0;
        adr_phase = 1'b0;
        strobe = 1'b0;
        rd_access = 1'b0;
        wr_access = 1'b0;
        bus_o = 16'h0000;
        bus_oe = 16'h0000;
        own = 16'h0000;
        alt = 1'b0;
        drv = 1'b0;
        en = 1'b0;
        next_st = st;
        next_st.done = 1'b0;
        next_st.rdata = 16'h0000;

        // Boot source caught at the first edge after reset release
        if (st.in_reset) begin
            next_st.in_reset = 1'b0;
            next_st.boot_ext = ~fetch_lvl; // RULE_06 RULE_07
        end

        if (REG_WR) begin
            case (REG_ADDR)
                ebp_pkg::OFF_SYS_CFG: begin
                    // Mode and style stay frozen while an access is running
                    if (!busy) begin
                        next_st.sys_cfg = {10'h000, REG_WDATA[5:0]}; // RULE_04
                    end
                end
                ebp_pkg::OFF_MUX_DIR: next_st.mux_dir = REG_WDATA;
                ebp_pkg::OFF_MUX_OUT: next_st.mux_out = REG_WDATA;
                ebp_pkg::OFF_ADR_DIR: next_st.adr_dir = REG_WDATA;
                ebp_pkg::OFF_ADR_OUT: next_st.adr_out = REG_WDATA;
                ebp_pkg::OFF_SEL_DIR: next_st.sel_dir = REG_WDATA[3:0];
                ebp_pkg::OFF_SEL_CTRL: begin
                    next_st.sel_out = REG_WDATA[ebp_pkg::SEL_OUT_LSB +: 4];
                    next_st.sel_od = REG_WDATA[ebp_pkg::SEL_OD_LSB +: 4];
                    next_st.sel_alt = REG_WDATA[ebp_pkg::SEL_ALT_LSB +: 4];
                end
                default: begin
                    if (REG_ADDR >= ebp_pkg::OFF_CS_WIN_FIRST && REG_ADDR <= ebp_pkg::OFF_CS_WIN_LAST) begin
                        next_st.cs_win[win_index(REG_ADDR)] = REG_WDATA;
                    end
                end
            endcase
        end
        if (REG_RD) begin
            next_st.rdata = rd_val;
        end

        // Remember a demultiplexed phase until single chip mode is entered
        if (demux_mode) begin
            next_st.was_demux = 1'b1; // RULE_13
        end else if (!ext_mode) begin
            next_st.was_demux = 1'b0;
        end

        case (st.fsm)
            ebp_pkg::ST_IDLE: begin
                if (REQ_VALID && REQ_READY) begin
                    next_st.req = REQ;
                    next_st.done_rdata = 16'h0000;
                    if (mux_mode) begin
                        next_st.fsm = ebp_pkg::ST_ALE; // RULE_05
                        next_st.cnt = ebp_pkg::ALE_CYCLES;
                    end else begin
                        next_st.fsm = ebp_pkg::ST_STROBE;
                        next_st.cnt = ebp_pkg::STROBE_CYCLES;
                    end
                end
            end
            ebp_pkg::ST_ALE: begin
                next_st.cnt = 3'(st.cnt - 3'h1);
                if (st.cnt == 3'h1) begin
                    next_st.fsm = ebp_pkg::ST_GAP; // RULE_20
                    next_st.cnt = ebp_pkg::GAP_CYCLES;
                end
            end
            ebp_pkg::ST_GAP: begin
                next_st.cnt = 3'(st.cnt - 3'h1);
                if (st.cnt == 3'h1) begin
                    next_st.fsm = ebp_pkg::ST_STROBE;
                    next_st.cnt = ebp_pkg::STROBE_CYCLES;
                end
            end
            ebp_pkg::ST_STROBE: begin
                next_st.cnt = 3'(st.cnt - 3'h1);
                if (st.cnt == 3'h1) begin
                    next_st.fsm = ebp_pkg::ST_FINISH;
                end
            end
            ebp_pkg::ST_FINISH: begin
                next_st.done = 1'b1;
                next_st.fsm = ebp_pkg::ST_IDLE;
                if (!st.req.write) begin
                    next_st.done_rdata = bus8 ? {8'h00, mux_lvl[7:0]} : mux_lvl;
                end
            end
            default: begin
                next_st.fsm = ebp_pkg::ST_IDLE;
            end
        endcase

        // Pin values follow the next state so they line up with it
        active = (next_st.fsm != ebp_pkg::ST_IDLE);
        adr_phase = (next_st.fsm == ebp_pkg::ST_ALE) || (next_st.fsm == ebp_pkg::ST_GAP);
        strobe = (next_st.fsm == ebp_pkg::ST_STROBE);
        rd_access = strobe & ~next_st.req.write;
        wr_access = strobe & next_st.req.write;
        next_st.ale = (next_st.fsm == ebp_pkg::ST_ALE); // RULE_05 RULE_20
        next_st.read_n = ~rd_access; // RULE_01 RULE_19
        next_st.low_store_n = ~(wr_access & (~low_style | bus8 | next_st.req.be[0])); // RULE_02 RULE_03
        next_st.high_store_n = ~(wr_access & low_style & ~bus8 & next_st.req.be[1]); // RULE_17
        next_st.cs_n = active ? ~cs_hit : 4'hF; // RULE_19

        if (active) begin
            if (adr_phase) begin
                bus_o = next_st.req.addr[15:0]; // RULE_09 RULE_11
                bus_oe = 16'hFFFF;
            end else begin
                if (next_st.req.write) begin
                    bus_o = next_st.req.wdata; // RULE_09 RULE_10
                    bus_oe = 16'hFFFF;
                end
                if (mux_mode && bus8) begin
                    bus_o[15:8] = next_st.req.addr[15:8]; // RULE_11
                    bus_oe[15:8] = 8'hFF;
                end
            end
        end
        own = {{8{mux_high_own}}, {8{ext_mode}}}; // RULE_10
        next_st.mux_o = (own & bus_o) | (~own & st.mux_out); // RULE_08
        next_st.mux_oe = (own & bus_oe) | (~own & st.mux_dir); // RULE_08

        next_st.adr_o = adr_own ? next_st.req.addr[15:0] : st.adr_out; // RULE_13
        next_st.adr_oe = adr_own ? 16'hFFFF : st.adr_dir; // RULE_12
        next_st.seg_o = next_st.req.addr[21:16]; // RULE_18
        next_st.seg_oe = ext_mode ? seg_mask(st.sys_cfg[ebp_pkg::SYS_SEG_LSB +: 2]) : 6'h00; // RULE_16 RULE_18

        for (int i = 0; i < 4; i++) begin
            alt = st.sel_alt[i] & (LARGE_DERIVATIVE | (i < ebp_pkg::CS_SMALL_COUNT)); // RULE_15
            drv = alt ? next_st.cs_n[i] : st.sel_out[i];
            en = alt | st.sel_dir[i]; // RULE_14
            next_st.sel_o[i] = drv;
            next_st.sel_oe[i] = en & (~st.sel_od[i] | ~drv); // RULE_14
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            st <= '0;
            st.fsm <= ebp_pkg::ST_IDLE;
            st.sys_cfg <= ebp_pkg::SYS_CFG_RST;
            st.mux_dir <= ebp_pkg::DIR_RST;
            st.mux_out <= ebp_pkg::OUT_RST;
            st.adr_dir <= ebp_pkg::DIR_RST;
            st.adr_out <= ebp_pkg::OUT_RST;
            st.cs_win <= {ebp_pkg::CSW_RST, ebp_pkg::CSW_RST, ebp_pkg::CSW_RST, ebp_pkg::CSW_RST};
            st.in_reset <= 1'b1;
            st.read_n <= 1'b1;
            st.low_store_n <= 1'b1;
            st.high_store_n <= 1'b1;
            st.cs_n <= 4'hF;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign REG_RDATA = st.rdata;
    assign DONE = st.done;
    assign DONE_RDATA = st.done_rdata;
    assign BOOT_EXTERNAL = st.boot_ext;
    assign READ_STROBE_N = st.read_n;
    assign LOW_BYTE_STORE_STROBE_N = st.low_store_n;
    assign HIGH_BYTE_STORE_STROBE_N = st.high_store_n;
    assign ADDRESS_LATCH = st.ale;
    assign MUXED_BUS_O = st.mux_o;
    assign MUXED_BUS_OE = st.mux_oe;
    assign ADDRESS_PORT_O = st.adr_o;
    assign ADDRESS_PORT_OE = st.adr_oe;
    assign SELECT_PORT_O = st.sel_o;
    assign SELECT_PORT_OE = st.sel_oe;
    assign SEGMENT_O = st.seg_o;
    assign SEGMENT_OE = st.seg_oe;

endmodule

// [testbench/ebp_pins_sva.sv]
// Checker of strobe, latch and port timing
module ebp_pins_sva (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic REG_RD,
    input wire logic [15:0] REG_RDATA,
    input wire logic REQ_VALID,
    input wire logic REQ_READY,
    input wire logic DONE,
    input wire logic READ_STROBE_N,
    input wire logic LOW_BYTE_STORE_STROBE_N,
    input wire logic HIGH_BYTE_STORE_STROBE_N,
    input wire logic ADDRESS_LATCH,
    input wire logic [15:0] MUXED_BUS_OE,
    input wire logic [3:0] SELECT_PORT_OE
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);
    wire logic ws_n = LOW_BYTE_STORE_STROBE_N & HIGH_BYTE_STORE_STROBE_N;
    wire logic quiet = READ_STROBE_N & ws_n;
    a_read_width: assert property ($fell(READ_STROBE_N) |-> !READ_STROBE_N [*4] ##1 READ_STROBE_N)
        else $error("read width");
    a_store_width: assert property ($fell(ws_n) |-> !ws_n [*4] ##1 ws_n)
        else $error("store width");
    a_read_no_drive: assert property (!READ_STROBE_N |-> ws_n && MUXED_BUS_OE[7:0] == 8'h00)
        else $error("bus driven in read");
    a_latch_pulse: assert property ($rose(ADDRESS_LATCH) |-> MUXED_BUS_OE == 16'hFFFF ##1
        !ADDRESS_LATCH && quiet) else $error("latch phase");
    a_done_after: assert property ($rose(DONE) |-> $past(quiet) && !$past(quiet, 2))
        else $error("done early");
    a_done_pulse: assert property (DONE |=> !DONE)
        else $error("done too long");
    a_ready_busy: assert property (REQ_VALID && REQ_READY |=> !REQ_READY [*5])
        else $error("ready while busy");
    a_reset_quiet: assert property ($rose(RSTN) |-> quiet && !ADDRESS_LATCH && !REQ_READY
        && MUXED_BUS_OE == 16'h0000 && SELECT_PORT_OE == 4'h0) else $error("active after reset");
    a_rdata_once: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
        else $error("stray read data");
    cover property ($rose(ADDRESS_LATCH));
    cover property ($fell(READ_STROBE_N));
    cover property ($fell(HIGH_BYTE_STORE_STROBE_N));
endmodule

bind ebp_pins ebp_pins_sva ebp_pins_sva_inst (.*);

// [testbench/ebp_mem_model.sv]
// External memory model
module ebp_mem_model (
    input wire logic clk,
    input wire logic use_latch,
    input wire logic lanes,
    input wire logic rd_n,
    input wire logic wl_n,
    input wire logic wh_n,
    input wire logic ale,
    input wire logic [15:0] bus_o,
    input wire logic [15:0] bus_oe,
    input wire logic [15:0] adr_o,
    output logic [15:0] bus_i
);
    logic [15:0] mem [256];
    logic [15:0] latched = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic [7:0] idx;
    logic [15:0] word;
    assign idx = use_latch ? latched[7:0] : adr_o[7:0];
    assign word = mem[idx];
    // Released lines read memory data under the read strobe, else the last read word inverted
    assign bus_i = (bus_o & bus_oe) | ((rd_n ? ~last : word) & ~bus_oe);
    always @(posedge clk) begin
        if (ale) latched <= bus_i;
        if (!rd_n) last <= word;
        if (!wl_n) mem[idx][7:0] <= bus_i[7:0];
        if ((!wl_n && !lanes) || !wh_n) mem[idx][15:8] <= bus_i[15:8];
    end
endmodule

// [testbench/test_ebp_pins.sv]
// Self-checking bench
module test_ebp_pins;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0, use_latch = 1'b0, lanes = 1'b0;
    logic fetch_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    ebp_pkg::ebp_req_t req = '0;
    logic req_ready, done, boot_ext, rd_n, wl_n, wh_n, ale;
    logic [15:0] reg_rdata, done_rdata, mux_o, mux_oe, mux_i, adr_o, adr_oe, adr_i, got;
    logic [3:0] sel_o, sel_oe, sel_i, cs_seen;
    logic [5:0] seg_o, seg_oe;
    int n_mismatch = 0, n_checks = 0, cyc = 0, n_rd, n_wl, n_wh, n_ale;
    always #10 clk = ~clk;
    // Released pins read back inverted
    assign adr_i = ~(adr_o ^ adr_oe);
    assign sel_i = ~(sel_o ^ sel_oe);
    ebp_pins ebp_pins_inst (.REF_CLK(clk), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REQ_VALID(req_valid), .REQ_READY(req_ready),
        .REQ(req), .DONE(done), .DONE_RDATA(done_rdata), .BOOT_EXTERNAL(boot_ext),
        .EXTERNAL_FETCH_SELECT_N(fetch_n), .READ_STROBE_N(rd_n), .LOW_BYTE_STORE_STROBE_N(wl_n),
        .HIGH_BYTE_STORE_STROBE_N(wh_n), .ADDRESS_LATCH(ale), .MUXED_BUS_I(mux_i), .MUXED_BUS_O(mux_o),
        .MUXED_BUS_OE(mux_oe), .ADDRESS_PORT_I(adr_i), .ADDRESS_PORT_O(adr_o), .ADDRESS_PORT_OE(adr_oe),
        .SELECT_PORT_I(sel_i), .SELECT_PORT_O(sel_o), .SELECT_PORT_OE(sel_oe), .SEGMENT_O(seg_o), .SEGMENT_OE(seg_oe));
    ebp_mem_model ebp_mem_model_inst (.clk(clk), .use_latch(use_latch), .lanes(lanes), .rd_n(rd_n), .wl_n(wl_n),
        .wh_n(wh_n), .ale(ale), .bus_o(mux_o), .bus_oe(mux_oe), .adr_o(adr_o), .bus_i(mux_i));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: %h not %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        chk(reg_rdata, e);
    endtask
    task automatic acc(input logic w, input logic [21:0] a, input logic [1:0] be, input logic [15:0] d);
        {n_rd, n_wl, n_wh, n_ale} = '0;
        cs_seen = 4'h0;
        @(posedge clk);
        req <= '{write: w, fetch: 1'b0, addr: a, be: be, wdata: d};
        req_valid <= 1'b1;
        @(posedge clk);
        while (req_ready !== 1'b1) @(posedge clk);
        req_valid <= 1'b0;
        for (int k = 0; k < 20 && done !== 1'b1; k++) begin
            @(posedge clk);
            n_rd += !rd_n;
            n_wl += !wl_n;
            n_wh += !wh_n;
            n_ale += ale;
            cs_seen |= ~sel_o;
        end
        got = done_rdata;
    endtask
    task automatic counts(input int r, input int l, input int h, input int a);
        chk(16'(n_rd), 16'(r));
        chk(16'(n_wl), 16'(l));
        chk(16'(n_wh), 16'(h));
        chk(16'(n_ale), 16'(a));
    endtask
    always @(posedge clk) begin
        if (++cyc == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        chk({15'h0000, boot_ext}, 16'h0001);
        rd(ebp_pkg::OFF_STATUS, 16'h0001);
        wr(ebp_pkg::OFF_SYS_CFG, 16'hFFFF);
        rd(ebp_pkg::OFF_SYS_CFG, 16'h003F);
        req_valid <= 1'b1;
        repeat (3) @(posedge clk);
        chk({15'h0000, req_ready}, 16'h0000);
        req_valid <= 1'b0;
        wr(ebp_pkg::OFF_MUX_DIR, 16'h00FF);
        wr(ebp_pkg::OFF_MUX_OUT, 16'h12A5);
        wr(ebp_pkg::OFF_SEL_DIR, 16'h000F);
        wr(ebp_pkg::OFF_SEL_CTRL, 16'h00F5);
        repeat (2) @(posedge clk);
        chk(mux_oe, 16'h00FF);
        chk({8'h00, mux_o[7:0]}, 16'h00A5);
        chk({12'h000, sel_oe}, 16'h000A);
        wr(ebp_pkg::OFF_SEL_CTRL, 16'h0F00);
        wr(ebp_pkg::OFF_CS_WIN_FIRST, 16'hFF00);
        wr(ebp_pkg::OFF_CS_WIN_FIRST + 4'h1, 16'hFF01);
        wr(ebp_pkg::OFF_SYS_CFG, 16'h000D);
        acc(1'b1, 22'h2A0012, 2'b11, 16'hBEEF);
        counts(0, 4, 0, 0);
        chk(adr_o, 16'h0012);
        chk(adr_oe, 16'hFFFF);
        chk({10'h000, seg_o}, 16'h002A);
        chk({12'h000, cs_seen}, 16'h0000);
        acc(1'b0, 22'h2A0012, 2'b11, 16'h0000);
        chk(got, 16'hBEEF);
        counts(4, 0, 0, 0);
        use_latch <= 1'b1;
        lanes <= 1'b1;
        wr(ebp_pkg::OFF_SYS_CFG, 16'h001E);
        acc(1'b1, 22'h000040, 2'b11, 16'h1234);
        counts(0, 4, 4, 1);
        chk({12'h000, cs_seen}, 16'h0001);
        acc(1'b1, 22'h008040, 2'b10, 16'h5600);
        counts(0, 0, 4, 1);
        chk({12'h000, cs_seen}, 16'h0002);
        acc(1'b1, 22'h000040, 2'b01, 16'h0078);
        counts(0, 4, 0, 1);
        acc(1'b0, 22'h000040, 2'b11, 16'h0000);
        chk(got, 16'h5678);
        counts(4, 0, 0, 1);
        chk(adr_o, 16'h0040);
        chk(adr_oe, 16'hFFFF);
        wr(ebp_pkg::OFF_SYS_CFG, 16'h003E);
        acc(1'b1, 22'h000041, 2'b10, 16'h009A);
        counts(0, 4, 0, 1);
        acc(1'b0, 22'h000041, 2'b01, 16'h0000);
        chk({8'h00, got[7:0]}, 16'h009A);
        report_and_stop();
    end
endmodule
